// >>> design/dist_filter.sv
// distance filter: median plus average, switching comparator, alarm and indicator
// assumes samples arrive on aclk as one-cycle valid pulses, at least 4 cycles apart
// Function
// - switching output asserts when filtered distance crosses point or window
// - hysteresis acts one way so output does not chatter
// - point mode uses upper point; window mode uses both points
// - polarity setting inverts switching output level
// - three precision levels: standard, high, very high
// - higher precision lengthens response, sample rate unchanged
// - filter is a moving median followed by a moving average
// - median keeps last N samples and outputs the middle value
// - median output follows a step after about half the buffer
// - average keeps last N samples and outputs their mean
// - high level settles after 4 plus 16 stable samples
// - very high level settles after 8 plus 128 stable samples
// - hysteresis is held as a millimetre distance
// - hysteresis sign puts band before or after the switch point
// - alarm output is fixed and active high
// - indicator on for no object, off with gain, flashes without
// - with no object, last distance is kept and alarm high
// - alarm has no hysteresis on the gain condition
// - three stored setups and an unsaved-changes flag
//
// Implementation choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps
module dist_filter
  import dist_filter_pkg::*;
#(
  parameter int led_half = led_half_cyc
)(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // measurement stream
  input wire sample_type smp,
  // pins
  output logic switch_out,
  output logic fault_signal_pin,
  output logic led_red,
  // axi4-lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  cfg_type cfg_q;
  cfg_type setup_mem [3];
  logic unsaved_q;
  logic [1:0] setup_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic aw_full_q, w_full_q, do_wr;
  logic sw_act_q, flash_q;
  logic [15:0] filt_q;
  logic [22:0] flash_cnt_q;

  // write channel: address and data taken in either order
  wire aw_take = awvalid && awready;
  wire w_take = wvalid && wready;
  assign do_wr = aw_full_q && w_full_q && !bvalid;
  wire aw_full_d = (aw_full_q && !do_wr) || aw_take;
  wire w_full_d = (w_full_q && !do_wr) || w_take;
  wire wr_hit = do_wr && (aw_addr_q <= setup_off) && (aw_addr_q[1:0] == 2'b00);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= resp_okay;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
    end
    else
    begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      awready <= !aw_full_d;
      wready <= !w_full_d;
      if (aw_take) aw_addr_q <= awaddr;
      if (w_take) w_data_q <= wdata;
      if (do_wr)
      begin
        bvalid <= 1'b1;
        bresp <= wr_hit ? resp_okay : resp_slverr;
      end
      else if (bready) bvalid <= 1'b0;
    end
  end

  // configuration and setup store; byte strobes ignored, whole-word writes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg_q <= cfg_reset;
      unsaved_q <= 1'b0;
      setup_q <= 2'h0;
    end
    else if (wr_hit)
    begin
      unique case (aw_addr_q)
        ctrl_off:
        begin
          cfg_q.window_mode <= w_data_q[ctrl_window_bit];
          cfg_q.active_low <= w_data_q[ctrl_low_bit];
          cfg_q.hyst_pos <= w_data_q[ctrl_hpos_bit];
          if (w_data_q[ctrl_prec_lsb+:2] != 2'b11)
            cfg_q.prec <= prec_type'(w_data_q[ctrl_prec_lsb+:2]);
          unsaved_q <= 1'b1;
        end
        upper_off:
        begin
          cfg_q.upper_switch_point <= w_data_q[15:0];
          unsaved_q <= 1'b1;
        end
        lower_off:
        begin
          cfg_q.lower_switch_point <= w_data_q[15:0];
          unsaved_q <= 1'b1;
        end
        hyst_off:
        begin
          cfg_q.hyst_mm <= w_data_q[15:0];
          unsaved_q <= 1'b1;
        end
        default:
        begin
          // setup command; an index of 3 is ignored
          if (w_data_q[1:0] != setup_count)
          begin
            setup_q <= w_data_q[1:0];
            if (w_data_q[setup_load_bit])
            begin
              cfg_q <= setup_mem[w_data_q[1:0]];
              unsaved_q <= 1'b0;
            end
            else if (w_data_q[setup_store_bit]) unsaved_q <= 1'b0;
          end
        end
      endcase
    end
  end

  // setup storage is a memory: kept across reset, like the non-volatile store
  always_ff @(posedge aclk)
  begin
    if (wr_hit && aw_addr_q == setup_off && w_data_q[setup_store_bit]
        && !w_data_q[setup_load_bit] && w_data_q[1:0] != setup_count)
      setup_mem[w_data_q[1:0]] <= cfg_q;
  end

  // read channel, one cycle to answer
  wire ar_take = arvalid && arready;
  wire rvalid_d = ar_take || (rvalid && !rready);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= resp_okay;
    end
    else
    begin
      arready <= !rvalid_d;
      rvalid <= rvalid_d;
      if (ar_take)
      begin
        rresp <= resp_okay;
        unique case (araddr)
          ctrl_off: rdata <= {26'h0, cfg_q.prec, 1'b0, cfg_q.hyst_pos,
                              cfg_q.active_low, cfg_q.window_mode};
          upper_off: rdata <= {16'h0000, cfg_q.upper_switch_point};
          lower_off: rdata <= {16'h0000, cfg_q.lower_switch_point};
          hyst_off: rdata <= {16'h0000, cfg_q.hyst_mm};
          setup_off: rdata <= {30'h0, setup_q};
          status_off: rdata <= {25'h0, smp.gain_ok, setup_q, unsaved_q,
                                led_red, fault_signal_pin, switch_out};
          filt_off: rdata <= {16'h0000, filt_q};
          default:
          begin
            rdata <= 32'h0000_0000;
            rresp <= resp_slverr;
          end
        endcase
      end
    end
  end

  // median stage: shift in object samples only, so no-object keeps the last value
  logic [15:0] med_buf_q [med_depth];
  logic med_v_q, avg_in_v_q, cmp_v_q;
  logic [3:0] med_len;
  logic [2:0] avg_sh;
  wire take_smp = smp.valid && !smp.no_object;
  always_comb
  begin
    unique case (cfg_q.prec)
      prec_high:
      begin
        med_len = med_len_high;
        avg_sh = avg_sh_high;
      end
      prec_vhigh:
      begin
        med_len = med_len_vhigh;
        avg_sh = avg_sh_vhigh;
      end
      default:
      begin
        med_len = med_len_std;
        avg_sh = avg_sh_std;
      end
    endcase
  end
  always_ff @(posedge aclk)
  begin
    if (take_smp)
    begin
      med_buf_q[0] <= smp.dist_mm;
      for (int i = 1; i < med_depth; i++) med_buf_q[i] <= med_buf_q[i-1];
    end
  end

  // rank of each entry among the first med_len; ties broken by position
  logic [3:0] rank [med_depth];
  logic [15:0] pick [med_depth];
  for (genvar i = 0; i < med_depth; i++)
  begin : g_rank
    always_comb
    begin
      rank[i] = 4'h0;
      for (int j = 0; j < med_depth; j++)
        if (j < int'(med_len) && j != i && (med_buf_q[j] < med_buf_q[i]
            || (med_buf_q[j] == med_buf_q[i] && j < i)))
          rank[i] = rank[i] + 4'h1;
      pick[i] = (i < int'(med_len) && rank[i] == (med_len >> 1)) ? med_buf_q[i] : 16'h0000;
    end
  end
  logic [15:0] med_d;
  always_comb
  begin
    med_d = 16'h0000;
    for (int i = 0; i < med_depth; i++) med_d = med_d | pick[i];
  end

  // average stage: ring of last samples and a running sum
  logic [15:0] avg_mem [avg_depth];
  logic [6:0] avg_ptr_q;
  logic [7:0] avg_fill_q;
  logic [22:0] avg_sum_q;
  prec_type prec_last_q;
  wire [7:0] avg_len = 8'(9'h001 << avg_sh);
  wire [6:0] old_idx = avg_ptr_q - avg_len[6:0];
  wire [15:0] old_val = (avg_fill_q >= avg_len) ? avg_mem[old_idx] : 16'h0000;
  always_ff @(posedge aclk)
  begin
    if (med_v_q) avg_mem[avg_ptr_q] <= med_d;
  end
  // precision change restarts the average so the old length does not linger
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      med_v_q <= 1'b0;
      avg_in_v_q <= 1'b0;
      cmp_v_q <= 1'b0;
      avg_ptr_q <= 7'h00;
      avg_fill_q <= 8'h00;
      avg_sum_q <= 23'h00_0000;
      filt_q <= 16'h0000;
      prec_last_q <= prec_std;
    end
    else
    begin
      med_v_q <= take_smp;
      avg_in_v_q <= med_v_q;
      cmp_v_q <= avg_in_v_q;
      prec_last_q <= cfg_q.prec;
      if (prec_last_q != cfg_q.prec)
      begin
        avg_fill_q <= 8'h00;
        avg_sum_q <= 23'h00_0000;
      end
      else if (med_v_q)
      begin
        // median taken straight from the buffer, so the average does not lag one sample
        avg_sum_q <= avg_sum_q + 23'(med_d) - 23'(old_val);
        avg_ptr_q <= avg_ptr_q + 7'h01;
        if (avg_fill_q < avg_len) avg_fill_q <= avg_fill_q + 8'h01;
      end
      if (avg_in_v_q) filt_q <= 16'(avg_sum_q >> avg_sh);
    end
  end

  // comparator thresholds, signed to keep hysteresis from wrapping
  logic signed [17:0] d, p1, p2, h, on_thr, off_thr;
  logic in_enter, in_stay, act_d;
  always_comb
  begin
    d = signed'({2'b00, filt_q});
    p1 = signed'({2'b00, cfg_q.upper_switch_point});
    p2 = signed'({2'b00, cfg_q.lower_switch_point});
    h = signed'({2'b00, cfg_q.hyst_mm});
    on_thr = cfg_q.hyst_pos ? p1 + h : p1;
    off_thr = cfg_q.hyst_pos ? p1 : p1 - h;
    if (cfg_q.hyst_pos)
    begin
      in_enter = d >= p2 + h && d <= p1 - h;
      in_stay = d >= p2 && d <= p1;
    end
    else
    begin
      in_enter = d >= p2 && d <= p1;
      in_stay = d >= p2 - h && d <= p1 + h;
    end
    if (cfg_q.window_mode) act_d = sw_act_q ? in_stay : in_enter;
    else act_d = sw_act_q ? d >= off_thr : d > on_thr;
  end

  // switching output; state updated once per filtered value, polarity applied every cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sw_act_q <= 1'b0;
      switch_out <= 1'b0;
    end
    else
    begin
      if (cmp_v_q) sw_act_q <= act_d;
      switch_out <= sw_act_q ^ cfg_q.active_low;
    end
  end

  // alarm re-evaluated every sample, indicator every cycle, both with no hysteresis
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fault_signal_pin <= 1'b0;
      led_red <= 1'b0;
      flash_q <= 1'b0;
      flash_cnt_q <= 23'h00_0000;
    end
    else
    begin
      if (flash_cnt_q >= 23'(led_half - 1))
      begin
        flash_cnt_q <= 23'h00_0000;
        flash_q <= !flash_q;
      end
      else flash_cnt_q <= flash_cnt_q + 23'h00_0001;
      if (smp.valid) fault_signal_pin <= smp.no_object;
      if (smp.no_object) led_red <= 1'b1;
      else if (smp.gain_ok) led_red <= 1'b0;
      else led_red <= flash_q;
    end
  end

  // checks
  sequence s_std_sample;
    smp.valid && !smp.no_object && cfg_q.prec == prec_std && !med_v_q && !avg_in_v_q;
  endsequence
  sequence s_std_out;
    ##3 filt_q == $past(smp.dist_mm, 3);
  endsequence
  chk_std_passthru: assert property (@(posedge aclk) disable iff (!aresetn)
    s_std_sample ##0 $stable(cfg_q.prec) [*1] |-> s_std_out)
    else $error("standard precision value not passed through");
  chk_alarm_noobj: assert property (@(posedge aclk) disable iff (!aresetn)
    smp.valid && smp.no_object |=> fault_signal_pin && led_red)
    else $error("alarm not high with no object");
  chk_alarm_obj: assert property (@(posedge aclk) disable iff (!aresetn)
    smp.valid && !smp.no_object |=> !fault_signal_pin)
    else $error("alarm high with object present");
  chk_hold_median: assert property (@(posedge aclk) disable iff (!aresetn)
    smp.valid && smp.no_object && !med_v_q |=> !med_v_q ##1 !avg_in_v_q)
    else $error("no-object sample entered the filter");
  chk_point_on: assert property (@(posedge aclk) disable iff (!aresetn)
    cmp_v_q && !cfg_q.window_mode && d > on_thr |=> sw_act_q)
    else $error("point mode failed to switch on");
  chk_point_hyst: assert property (@(posedge aclk) disable iff (!aresetn)
    cmp_v_q && !cfg_q.window_mode && sw_act_q && d >= off_thr |=> sw_act_q)
    else $error("point mode released inside hysteresis");
  chk_window_in: assert property (@(posedge aclk) disable iff (!aresetn)
    cmp_v_q && cfg_q.window_mode && in_enter |=> sw_act_q)
    else $error("window mode not active inside window");
  chk_polarity_out: assert property (@(posedge aclk) disable iff (!aresetn)
    switch_out == $past(sw_act_q ^ cfg_q.active_low))
    else $error("switching output polarity wrong");
  chk_unsaved_set: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_hit && aw_addr_q == upper_off |=> unsaved_q ##1 (unsaved_q || wr_hit))
    else $error("unsaved flag not raised");
endmodule : dist_filter

// >>> design/dist_filter_pkg.sv
// constants, register map and carrier types of the distance filter block
// assumes one 125 MHz clock and an axi4-lite register master
package dist_filter_pkg;
  // register byte offsets
  localparam logic [7:0] ctrl_off = 8'h00;
  localparam logic [7:0] upper_off = 8'h04;
  localparam logic [7:0] lower_off = 8'h08;
  localparam logic [7:0] hyst_off = 8'h0C;
  localparam logic [7:0] setup_off = 8'h10;
  localparam logic [7:0] status_off = 8'h14;
  localparam logic [7:0] filt_off = 8'h18;
  // ctrl fields
  localparam int ctrl_window_bit = 0;
  localparam int ctrl_low_bit = 1;
  localparam int ctrl_hpos_bit = 2;
  localparam int ctrl_prec_lsb = 4;
  // setup command fields
  localparam int setup_store_bit = 8;
  localparam int setup_load_bit = 9;
  localparam logic [1:0] setup_count = 2'h3;
  // axi answers
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
  // precision levels
  typedef enum logic [1:0] {
    prec_std = 2'b00,
    prec_high = 2'b01,
    prec_vhigh = 2'b10
  } prec_type;
  // median lengths give delays 1, 4 and 8 samples
  localparam logic [3:0] med_len_std = 4'h1;
  localparam logic [3:0] med_len_high = 4'h7;
  localparam logic [3:0] med_len_vhigh = 4'hF;
  localparam int med_depth = 15;
  // averaging lengths 1, 16, 128 as shifts
  localparam logic [2:0] avg_sh_std = 3'h0;
  localparam logic [2:0] avg_sh_high = 3'h4;
  localparam logic [2:0] avg_sh_vhigh = 3'h7;
  localparam int avg_depth = 128;
  // indicator flash timing
  localparam int clk_hz = 125_000_000;
  localparam int led_flash_hz = 8;
  localparam int led_half_cyc = clk_hz / (2 * led_flash_hz);
  // active configuration
  typedef struct packed {
    logic [15:0] upper_switch_point;
    logic [15:0] lower_switch_point;
    logic [15:0] hyst_mm;
    prec_type prec;
    logic window_mode;
    logic active_low;
    logic hyst_pos;
  } cfg_type;
  localparam cfg_type cfg_reset = '{16'h0000, 16'h0000, 16'h0000, prec_std, 1'b0, 1'b0, 1'b0};
  // one measurement from the acquisition side
  typedef struct packed {
    logic valid;
    logic no_object;
    logic gain_ok;
    logic [15:0] dist_mm;
  } sample_type;
endpackage : dist_filter_pkg

// >>> verification/meas_host.sv
// sample source standing in for the acquisition side of the filter
// assumes the stream contract: one valid pulse per sample, then a gap
`timescale 1ns/10ps
module meas_host
  import dist_filter_pkg::*;
(
  // clock
  input wire logic aclk,
  // stream into the block
  output sample_type smp
);
  // idle until the first sample
  initial smp = '0;

  // status levels stay up; the distance is scrambled once valid drops
  task automatic send(input logic [15:0] d, input logic no, input logic g);
    @(posedge aclk);
    smp <= '{1'b1, no, g, d};
    @(posedge aclk);
    smp <= '{1'b0, no, g, ~d};
    repeat (6) @(posedge aclk); // wide gap, pipeline needs 4
  endtask : send
endmodule : meas_host

// >>> verification/tb_top.sv
// self-checking bench for the distance filter block
// assumes dist_filter and meas_host share one 125 MHz clock
`timescale 1ns/10ps
module tb_top
  import dist_filter_pkg::*;
();
  localparam int half = 8;
  logic aclk;
  logic aresetn;
  sample_type smp;
  logic switch_out, fault_signal_pin, led_red;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  int err_count, n_checks, hi;

  // short flash period keeps the indicator test brief
  dist_filter #(.led_half(half)) dut (.aclk, .aresetn, .smp, .switch_out,
    .fault_signal_pin, .led_red, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready);
  meas_host far (.aclk, .smp);

  // 8 ns clock
  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic chk_pin(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask : chk_pin

  // address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge aclk);
      if (!aw_ok && awready === 1'b1)
      begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1)
      begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, e});
  endtask : wr

  // masked compare so status bits can be checked alone
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
    input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd_v = rdata;
    rready <= 1'b0;
    chk(rd_v & m, e);
    chk({30'h0, rresp}, {30'h0, er});
  endtask : rd

  task automatic sw(input logic [15:0] d, input logic e);
    far.send(d, 1'b0, 1'b1);
    chk_pin(switch_out, e);
  endtask : sw

  task automatic burst(input logic [15:0] d, input int n);
    repeat (n) far.send(d, 1'b0, 1'b1);
  endtask : burst

  // hang guard, far above the expected 3000 cycles
  initial
  begin
    #100us;
    err_count++;
    test_done();
  end

  // main sequence
  initial
  begin
    err_count = 0;
    n_checks = 0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'hF;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 4; i++)
      rd(8'(4 * i), 32'h0000_0000, 32'hFFFF_FFFF, resp_okay);
    wr(8'h1C, 32'h0000_0001, resp_slverr);
    wr(8'h02, 32'h0000_0001, resp_slverr);
    wr(filt_off, 32'h0000_0001, resp_slverr);
    rd(8'h20, 32'h0000_0000, 32'hFFFF_FFFF, resp_slverr);
    $display("test registers done");
    // point mode, negative band of 10 mm below 100 mm
    wr(upper_off, 32'h0000_0064, resp_okay);
    wr(lower_off, 32'h0000_0078, resp_okay);
    wr(hyst_off, 32'h0000_000A, resp_okay);
    sw(16'h0096, 1'b1);
    sw(16'h005F, 1'b1);
    sw(16'h005A, 1'b1);
    sw(16'h0059, 1'b0);
    sw(16'h0064, 1'b0);
    sw(16'h0065, 1'b1);
    wr(ctrl_off, 32'h0000_0002, resp_okay);
    sw(16'h0096, 1'b0);
    sw(16'h0050, 1'b1);
    wr(ctrl_off, 32'h0000_0004, resp_okay);
    sw(16'h0069, 1'b0);
    sw(16'h006F, 1'b1);
    sw(16'h0064, 1'b1);
    sw(16'h0063, 1'b0);
    $display("test point mode done");
    // window 50..200 mm, wider than any plausible minimum
    wr(lower_off, 32'h0000_0032, resp_okay);
    wr(upper_off, 32'h0000_00C8, resp_okay);
    wr(ctrl_off, 32'h0000_0001, resp_okay);
    sw(16'h002D, 1'b0);
    sw(16'h0032, 1'b1);
    sw(16'h00CD, 1'b1);
    sw(16'h00D3, 1'b0);
    sw(16'h0078, 1'b1);
    sw(16'h0028, 1'b1);
    sw(16'h0027, 1'b0);
    wr(ctrl_off, 32'h0000_0005, resp_okay);
    sw(16'h0037, 1'b0);
    sw(16'h003C, 1'b1);
    sw(16'h00C8, 1'b1);
    sw(16'h00C9, 1'b0);
    $display("test window mode done");
    // alarm and indicator across the three situations
    far.send(16'h012C, 1'b1, 1'b0);
    chk_pin(fault_signal_pin, 1'b1);
    chk_pin(led_red, 1'b1);
    chk_pin(switch_out, 1'b0);
    rd(filt_off, 32'h0000_00C9, 32'hFFFF_FFFF, resp_okay);
    far.send(16'h012C, 1'b0, 1'b1);
    chk_pin(fault_signal_pin, 1'b0);
    chk_pin(led_red, 1'b0);
    far.send(16'h012C, 1'b0, 1'b0);
    chk_pin(fault_signal_pin, 1'b0);
    hi = 0;
    repeat (4 * half)
    begin
      @(posedge aclk);
      hi += int'(led_red);
    end
    chk_pin(hi > 0 && hi < 4 * half, 1'b1);
    far.send(16'h012C, 1'b1, 1'b0);
    chk_pin(fault_signal_pin, 1'b1);
    $display("test alarm done");
    // store, edit, reload
    rd(status_off, 32'h0000_0008, 32'h0000_0008, resp_okay);
    wr(setup_off, 32'h0000_0101, resp_okay);
    rd(status_off, 32'h0000_0010, 32'h0000_0038, resp_okay);
    wr(upper_off, 32'h0000_1234, resp_okay);
    rd(status_off, 32'h0000_0008, 32'h0000_0008, resp_okay);
    wr(setup_off, 32'h0000_0201, resp_okay);
    rd(upper_off, 32'h0000_00C8, 32'hFFFF_FFFF, resp_okay);
    rd(status_off, 32'h0000_0010, 32'h0000_0038, resp_okay);
    rd(setup_off, 32'h0000_0001, 32'h0000_0003, resp_okay);
    $display("test setups done");
    // high precision: median 7, average 16
    wr(ctrl_off, 32'h0000_0010, resp_okay);
    burst(16'h01F4, 25);
    rd(filt_off, 32'h0000_01F4, 32'hFFFF_FFFF, resp_okay);
    burst(16'h0258, 3);
    rd(filt_off, 32'h0000_01F4, 32'hFFFF_FFFF, resp_okay);
    burst(16'h0258, 7);
    rd(filt_off, 32'h0000_0000, 32'h0000_0000, resp_okay);
    chk_pin(rd_v > 32'h0000_01F4 && rd_v < 32'h0000_0258, 1'b1);
    burst(16'h0258, 10);
    rd(filt_off, 32'h0000_0258, 32'hFFFF_FFFF, resp_okay);
    far.send(16'h0384, 1'b0, 1'b1);
    burst(16'h0258, 3);
    rd(filt_off, 32'h0000_0258, 32'hFFFF_FFFF, resp_okay);
    // very high precision: median 15, average 128
    wr(ctrl_off, 32'h0000_0020, resp_okay);
    burst(16'h0258, 136);
    rd(filt_off, 32'h0000_0258, 32'hFFFF_FFFF, resp_okay);
    burst(16'h02BC, 130);
    rd(filt_off, 32'h0000_0000, 32'h0000_0000, resp_okay);
    chk_pin(rd_v < 32'h0000_02BC, 1'b1);
    burst(16'h02BC, 6);
    rd(filt_off, 32'h0000_02BC, 32'hFFFF_FFFF, resp_okay);
    $display("test precision done");
    test_done();
  end
endmodule : tb_top
